// ==== sscl_pkg.sv ====
// Purpose: shared constants for the serial setup chain loader
// Assumes: 100 MHz core clock
// Notes:   counts are in core clock cycles
`default_nettype none
package sscl_pkg;
  localparam int unsigned SSCL_SETUP_LEN_DEF = 64;
  // core cycles after reset release before the mode strap is taken
  localparam int unsigned SSCL_STRAP_SETTLE  = 4;
  localparam logic        SSCL_DONE_N_RST    = 1'b1;
  localparam logic        SSCL_SO_RST        = 1'b0;
  localparam logic        SSCL_EN_N_RST      = 1'b1;
  localparam logic        SSCL_LVL_RST       = 1'b0;

  typedef enum logic [2:0]
  {
    SSCL_ST_STRAP = 3'b001,
    SSCL_ST_LOAD  = 3'b010,
    SSCL_ST_DONE  = 3'b100
  } sscl_state_type;
endpackage
`default_nettype wire

// ==== sscl_sync.sv ====
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pin is asynchronous to core_clk_in
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module sscl_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  output var  logic level_out
);
  logic meta_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic level_d;

  always_comb
  begin
    // first stage is read by the second stage only
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_q  <= RESET_VAL;
      s2_q    <= RESET_VAL;
      s3_q    <= RESET_VAL;
      level_q <= RESET_VAL;
    end
    else
    begin
      meta_q  <= pin_in;
      s2_q    <= meta_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;
endmodule
`default_nettype wire

// ==== sscl_loader.sv ====
// Purpose: serial setup chain loader, device side
// Assumes: serial clock far slower than core clock (several core cycles per phase)
// Notes:   serial clock is sampled, not used as a clock
//
// How it works
// - a data bit is captured on each serial clock rise while enable is low, until SETUP_LEN bits are loaded
// - once done, serial in goes to serial out whatever the done output
// - setup bits live in a shift register, one position per captured bit
// - serial out only carries forwarded data for downstream devices
// - after loading, the done output follows the enable input
// - done output low means ready for normal queue operation
// - serial loading only if the serial mode strap was chosen at master reset
`timescale 1ns/1ns
`default_nettype none
module sscl_loader
  import sscl_pkg::*;
#(
  parameter int unsigned SETUP_LEN = SSCL_SETUP_LEN_DEF
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 serial_prog_sel_in,
  input  wire logic                 serial_clk_in,
  input  wire logic                 serial_data_in,
  input  wire logic                 chain_enable_in_n,
  output var  logic                 serial_data_out,
  output var  logic                 chain_done_out_n,
  output var  logic                 setup_valid_out,
  output var  logic [SETUP_LEN-1:0] setup_bits_out
);
  localparam int unsigned CW = $clog2(SETUP_LEN + 1);
  localparam int unsigned SW = $clog2(SSCL_STRAP_SETTLE + 1);
  localparam logic [CW-1:0] LAST_BIT = CW'(SETUP_LEN - 1);
  localparam logic [SW-1:0] SETTLE   = SW'(SSCL_STRAP_SETTLE);

  logic sel_f;
  logic sclk_f;
  logic si_f;
  logic en_n_f;

  sscl_sync #(.RESET_VAL(SSCL_LVL_RST)) u_sync_sel
  (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .pin_in      (serial_prog_sel_in),
    .level_out   (sel_f)
  );

  sscl_sync #(.RESET_VAL(SSCL_LVL_RST)) u_sync_sclk
  (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .pin_in      (serial_clk_in),
    .level_out   (sclk_f)
  );

  sscl_sync #(.RESET_VAL(SSCL_LVL_RST)) u_sync_si
  (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .pin_in      (serial_data_in),
    .level_out   (si_f)
  );

  sscl_sync #(.RESET_VAL(SSCL_EN_N_RST)) u_sync_en
  (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .pin_in      (chain_enable_in_n),
    .level_out   (en_n_f)
  );

  // control state
  sscl_state_type       state_q;
  sscl_state_type       state_d;
  logic [SW-1:0]        settle_q;
  logic [SW-1:0]        settle_d;
  logic                 prog_sel_q;
  logic                 prog_sel_d;
  logic                 sclk_prev_q;
  logic [CW-1:0]        cnt_q;
  logic [CW-1:0]        cnt_d;
  logic [SETUP_LEN-1:0] setup_q;
  logic [SETUP_LEN-1:0] setup_d;
  logic [SETUP_LEN-1:0] setup_shift_w;
  logic                 capture_w;

  // output flops
  logic so_q;
  logic so_d;
  logic done_n_q;
  logic done_n_d;
  logic valid_q;
  logic valid_d;

  assign setup_shift_w = {setup_q[SETUP_LEN-2:0], si_f};
  assign capture_w = (state_q == SSCL_ST_LOAD) && sclk_f && !sclk_prev_q && !en_n_f;

  always_comb
  begin
    state_d    = state_q;
    settle_d   = settle_q;
    prog_sel_d = prog_sel_q;
    cnt_d      = cnt_q;
    setup_d    = setup_q;
    unique case (state_q)
      SSCL_ST_STRAP:
      begin
        // wait for the strap to pass the synchroniser before trusting it
        if (settle_q == SETTLE)
        begin
          prog_sel_d = sel_f;
          state_d    = sel_f ? SSCL_ST_LOAD : SSCL_ST_DONE;
        end
        else
        begin
          settle_d = settle_q + SW'(1);
        end
      end
      SSCL_ST_LOAD:
      begin
        if (capture_w)
        begin
          setup_d = setup_shift_w;
          if (cnt_q == LAST_BIT)
          begin
            state_d = SSCL_ST_DONE;
          end
          else
          begin
            cnt_d = cnt_q + CW'(1);
          end
        end
      end
      SSCL_ST_DONE:
      begin
        state_d = SSCL_ST_DONE;
      end
      default:
      begin
        state_d = SSCL_ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q     <= SSCL_ST_STRAP;
      settle_q    <= '0;
      prog_sel_q  <= 1'b0;
      sclk_prev_q <= SSCL_LVL_RST;
      cnt_q       <= '0;
      setup_q     <= '0;
    end
    else
    begin
      state_q     <= state_d;
      settle_q    <= settle_d;
      prog_sel_q  <= prog_sel_d;
      sclk_prev_q <= sclk_f;
      cnt_q       <= cnt_d;
      setup_q     <= setup_d;
    end
  end

  always_comb
  begin
    // forwarding costs one core cycle plus the synchroniser; fine at serial rates
    so_d     = (state_q == SSCL_ST_DONE) ? si_f : SSCL_SO_RST;
    done_n_d = (state_q == SSCL_ST_DONE) ? en_n_f : SSCL_DONE_N_RST;
    // taken from the next state so valid rises with the last capture
    valid_d  = (state_d == SSCL_ST_DONE);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      so_q     <= SSCL_SO_RST;
      done_n_q <= SSCL_DONE_N_RST;
      valid_q  <= 1'b0;
    end
    else
    begin
      so_q     <= so_d;
      done_n_q <= done_n_d;
      valid_q  <= valid_d;
    end
  end

  assign serial_data_out  = so_q;
  assign chain_done_out_n = done_n_q;
  assign setup_valid_out  = valid_q;
  assign setup_bits_out   = setup_q;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_capture;
    (state_q == SSCL_ST_LOAD) && sclk_f && !sclk_prev_q && !en_n_f;
  endsequence

  sequence s_idle_load;
    (state_q == SSCL_ST_LOAD) && !(sclk_f && !sclk_prev_q && !en_n_f);
  endsequence

  property p_shift;
    s_capture |=> setup_q == $past(setup_shift_w);
  endproperty

  a_capture_shift: assert property (p_shift)
    else $error("setup bit not shifted on serial clock rise");

  a_hold_idle: assert property (s_idle_load |=> $stable(setup_q) && $stable(cnt_q))
    else $error("setup moved without a capture");

  a_count_end: assert property (s_capture ##0 (cnt_q == LAST_BIT) |=> state_q == SSCL_ST_DONE)
    else $error("loading did not end at full length");

  a_no_early_end: assert property ((state_q == SSCL_ST_LOAD) ##1 (state_q == SSCL_ST_DONE)
                                   |-> $past(cnt_q) == LAST_BIT)
    else $error("loading ended early");

  a_so_forward: assert property ((state_q == SSCL_ST_DONE) |=> so_q == $past(si_f))
    else $error("serial out does not follow serial in");

  a_so_quiet: assert property ((state_q != SSCL_ST_DONE) |=> so_q == SSCL_SO_RST)
    else $error("serial out active before loading done");

  a_done_follow: assert property ((state_q == SSCL_ST_DONE) |=> chain_done_out_n == $past(en_n_f))
    else $error("done output does not follow enable");

  a_busy_high: assert property ((state_q != SSCL_ST_DONE) |=> chain_done_out_n)
    else $error("done output low before loading done");

  a_strap_mode: assert property ((state_q == SSCL_ST_STRAP) ##1 (state_q != SSCL_ST_STRAP)
                                 |-> (state_q == SSCL_ST_LOAD) == prog_sel_q)
    else $error("mode strap not honoured");

  a_default_empty: assert property ((state_q == SSCL_ST_DONE) && !prog_sel_q |-> cnt_q == '0)
    else $error("bits loaded without serial mode");

  a_valid_state: assert property (setup_valid_out == (state_q == SSCL_ST_DONE))
    else $error("valid output does not match loading state");
endmodule
`default_nettype wire

// ==== sscl_host_model.sv ====
// Purpose: host end of the serial setup link
// Assumes: 80 ns link clock, parked low between frames
// Notes:   data line shows the inverted last bit after a frame, until set_lines drives it
`timescale 1ns/1ns
`default_nettype none
module sscl_host_model (
  output var logic serial_clk_out,
  output var logic serial_data_out,
  output var logic chain_enable_out_n
);
  initial
  begin
    serial_clk_out     = 1'b0;
    serial_data_out    = 1'b0;
    chain_enable_out_n = 1'b1;
  end
  // whole stream goes to the first device only; msb of the slice first
  task automatic send(input logic [7:0] word, input int nbits, input logic en_n);
    int i;
    begin
      chain_enable_out_n = en_n;
      for (i = nbits - 1; i >= 0; i--)
      begin
        serial_data_out = word[i];
        #40 serial_clk_out = 1'b1;
        #40 serial_clk_out = 1'b0;
      end
      // released line: never leave a stale copy of the last bit
      serial_data_out = ~serial_data_out;
    end
  endtask
  task automatic set_lines(input logic d, input logic en_n);
    serial_data_out    = d;
    chain_enable_out_n = en_n;
  endtask
endmodule
`default_nettype wire

// ==== test_serial_setup_chain_loader.sv ====
// Purpose: self-checking bench for the serial setup chain loader
// Assumes: setup length shrunk to 8 bits
// Notes:   link lines come from the host model, core inputs at falling edge
`timescale 1ns/1ns
`default_nettype none
module test_serial_setup_chain_loader
  import sscl_pkg::*;
;
  logic       core_clk;
  logic       rst_n;
  logic       strap;
  logic       sclk;
  logic       sdata;
  logic       en_n;
  logic       so;
  logic       done_n;
  logic       valid;
  logic [7:0] bits;
  int         fail_count;
  int         checks_done;
  int         seed;
  logic       d;

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  sscl_host_model i_host (.serial_clk_out(sclk), .serial_data_out(sdata),
                          .chain_enable_out_n(en_n));
  sscl_loader #(.SETUP_LEN(8)) i_dut (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .serial_prog_sel_in(strap), .serial_clk_in(sclk), .serial_data_in(sdata),
    .chain_enable_in_n(en_n), .serial_data_out(so), .chain_done_out_n(done_n),
    .setup_valid_out(valid), .setup_bits_out(bits));

  function automatic logic [7:0] after_bits(input logic [7:0] v, input int n);
    return v >> (8 - n);
  endfunction

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
      fail_count++;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic close_out();
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // strap held well past its sampling point after release
  task automatic do_reset(input logic s);
    @(negedge core_clk);
    rst_n = 1'b0;
    strap = s;
    idle(3);
    chk("done_n in reset", {7'h00, done_n}, {7'h00, SSCL_DONE_N_RST});
    chk("so in reset", {7'h00, so}, {7'h00, SSCL_SO_RST});
    rst_n = 1'b1;
    idle(12);
  endtask

  task automatic load_run(input logic [7:0] w);
    int k;
    begin
      do_reset(1'b1);
      i_host.send(8'hA5, 4, 1'b1);
      idle(10);
      chk("bits enable high", bits, 8'h00);
      i_host.send(w >> 1, 7, 1'b0);
      idle(10);
      chk("bits partial", bits, after_bits(w, 7));
      chk("valid early", {7'h00, valid}, 8'h00);
      chk("so early", {7'h00, so}, 8'h00);
      chk("done_n early", {7'h00, done_n}, 8'h01);
      i_host.send(w, 1, 1'b0);
      idle(10);
      chk("bits full", bits, w);
      chk("valid", {7'h00, valid}, 8'h01);
      chk("done_n loaded", {7'h00, done_n}, 8'h00);
      i_host.send(~w, 8, 1'b0);
      idle(10);
      chk("bits after extra", bits, w);
      for (k = 0; k < 6; k++)
      begin
        d = 1'($random(seed));
        i_host.set_lines(d, 1'b0);
        idle(8);
        chk("so forward", {7'h00, so}, {7'h00, d});
      end
      // corner case: force a toggle so a stuck forward path cannot hide
      d = ~d;
      i_host.set_lines(d, 1'b0);
      idle(8);
      chk("so toggle", {7'h00, so}, {7'h00, d});
      i_host.set_lines(d, 1'b1);
      idle(8);
      chk("done_n follows", {7'h00, done_n}, 8'h01);
    end
  endtask

  initial
  begin
    seed        = 69;
    fail_count  = 0;
    checks_done = 0;
    rst_n       = 1'b0;
    strap       = 1'b1;
    load_run(8'($random(seed)));
    load_run(8'h01);
    load_run(8'($random(seed)));
    // default mode: serial traffic must not load anything
    do_reset(1'b0);
    i_host.send(8'hFF, 8, 1'b0);
    idle(10);
    chk("bits default", bits, 8'h00);
    chk("done_n default", {7'h00, done_n}, 8'h00);
    close_out();
  end

  // whole run takes under ten microseconds
  initial
  begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
